// ==== rtl/hci_uart_transport.v ====
`timescale 1ns/100ps
`include "hci_uart_map.vh"

module hci_uart_transport
#(
   parameter DEPTH       = 16,
   parameter AW          = 4,
   parameter THRESHOLD   = 12,
   parameter THREE_WIRE  = 1
)
(
   // clock and reset
   input  wire                clk_sys,
   input  wire                rst,
   // serial link
   input  wire                uart_rx_in,
   output reg                 uart_tx_out,
   output reg                 rx_throttle_out,
   input  wire                tx_throttle_in,
   // received bytes to controller
   output reg  [7:0]          rx_data,
   output reg                 rx_valid,
   input  wire                rx_ready,
   // bytes from controller
   input  wire [7:0]          tx_data,
   input  wire                tx_last,
   input  wire                tx_valid,
   output reg                 tx_ready,
   // configuration
   input  wire                parity_en,
   input  wire                parity_odd,
   input  wire                rate_req,
   input  wire [`DIV_W-1:0]   rate_div_in,
   input  wire                sleep_req,
   // status
   output reg  [`MODE_W-1:0]  mode,
   output reg                 rate_switched,
   output reg                 wake_event,
   output reg                 err_break,
   output reg                 err_idle,
   output reg                 err_framing,
   output reg                 err_overflow,
   output reg                 err_parity,
   output reg                 err_underflow
);

   // ====================================================
   // bit rate
   reg  [`DIV_W-1:0] div_q;
   reg  [`DIV_W-1:0] pend_div_q;
   reg               pend_q;
   wire              rx_mid;
   wire              tx_end;
   wire              rx_restart;
   wire              tx_restart;
   wire              apply_rate;

   function [`DIV_W-1:0] clamp_div;
      input [`DIV_W-1:0] d;
      begin
         clamp_div = (d < `MIN_DIV) ? `MIN_DIV : d; // R1
      end
   endfunction

   function is_flow_char;
      input [7:0] b;
      begin
         is_flow_char = (b == `XON_CHAR) || (b == `XOFF_CHAR);
      end
   endfunction

   bit_timer #(.DW(`DIV_W)) u_rx_timer
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .restart  (rx_restart),
      .div      (div_q),
      .mid_tick (rx_mid),
      .end_tick ()
   );

   bit_timer #(.DW(`DIV_W)) u_tx_timer
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .restart  (tx_restart),
      .div      (div_q),
      .mid_tick (),
      .end_tick (tx_end)
   );

   // ====================================================
   // receiver
   reg  [`ST_W-1:0]      rx_st_q;
   reg  [7:0]            rx_sh_q;
   reg  [`BIT_CNT_W-1:0] rx_cnt_q;
   reg                   rx_par_q;
   reg                   rx_prev_q;
   reg  [`IDLE_CNT_W-1:0] idle_cnt_q;
   reg                   active_q;
   reg                   xoff_q;
   wire                  stop_ok;
   wire                  byte_done;
   wire                  par_bad;

   assign rx_restart = (rx_st_q == `ST_IDLE) && rx_prev_q && !uart_rx_in;
   assign byte_done  = (rx_st_q == `ST_STOP) && rx_mid;
   assign stop_ok    = uart_rx_in;
   assign par_bad    = parity_en && (rx_par_q != (^rx_sh_q ^ parity_odd));

   // ====================================================
   // receive fifo
   reg  [7:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wr_q;
   reg  [AW-1:0] rd_q;
   reg  [AW:0]   cnt_q;
   wire        good_byte;
   wire        consumed;
   wire        push;
   wire        pop;
   wire        full;

   assign full      = (cnt_q == DEPTH);
   assign good_byte = byte_done && stop_ok && !par_bad;
   // flow characters are taken out of the stream in three-wire mode
   assign consumed  = (mode == `MODE_THREE) && is_flow_char(rx_sh_q); // R10
   assign push      = good_byte && !consumed && !full; // R12 R13
   assign pop       = (cnt_q != {(AW+1){1'b0}}) && (!rx_valid || rx_ready);

   always @(posedge clk_sys)
   begin
      if (push)
         mem[wr_q] <= rx_sh_q;
   end

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_st_q      <= `ST_IDLE;
         rx_sh_q      <= 8'h00;
         rx_cnt_q     <= {`BIT_CNT_W{1'b0}};
         rx_par_q     <= 1'b0;
         rx_prev_q    <= 1'b1;
         idle_cnt_q   <= {`IDLE_CNT_W{1'b0}};
         active_q     <= 1'b0;
         xoff_q       <= 1'b0;
         mode         <= `MODE_UNKNOWN;
         wr_q         <= {AW{1'b0}};
         rd_q         <= {AW{1'b0}};
         cnt_q        <= {(AW+1){1'b0}};
         rx_data      <= 8'h00;
         rx_valid     <= 1'b0;
         err_break    <= 1'b0;
         err_idle     <= 1'b0;
         err_framing  <= 1'b0;
         err_overflow <= 1'b0;
         err_parity   <= 1'b0;
      end
      else
      begin
         rx_prev_q    <= uart_rx_in;
         err_break    <= byte_done && !stop_ok && (rx_sh_q == 8'h00) && !rx_par_q; // R6
         err_framing  <= byte_done && !stop_ok; // R6
         err_parity   <= byte_done && stop_ok && par_bad; // R6
         err_overflow <= good_byte && !consumed && full; // R6
         err_idle     <= 1'b0;
         // idle: line quiet for ten bit times after traffic
         if (rx_st_q != `ST_IDLE || !uart_rx_in)
            idle_cnt_q <= {`IDLE_CNT_W{1'b0}};
         else if (rx_mid && active_q)
         begin
            if (idle_cnt_q == `IDLE_BITS - 4'h1)
            begin
               err_idle   <= 1'b1; // R6
               active_q   <= 1'b0;
               idle_cnt_q <= {`IDLE_CNT_W{1'b0}};
            end
            else
               idle_cnt_q <= idle_cnt_q + 4'h1;
         end
         case (rx_st_q)
            `ST_IDLE:
            begin
               if (rx_restart)
                  rx_st_q <= `ST_START;
            end
            `ST_START:
            begin
               if (rx_mid)
               begin
                  rx_st_q  <= uart_rx_in ? `ST_IDLE : `ST_DATA;
                  rx_cnt_q <= {`BIT_CNT_W{1'b0}};
                  active_q <= 1'b1;
               end
            end
            `ST_DATA:
            begin
               if (rx_mid)
               begin
                  rx_sh_q  <= {uart_rx_in, rx_sh_q[7:1]};
                  rx_cnt_q <= rx_cnt_q + 3'h1;
                  rx_par_q <= 1'b0;
                  if (rx_cnt_q == `DATA_BITS - 1)
                     rx_st_q <= parity_en ? `ST_PAR : `ST_STOP; // R5
               end
            end
            `ST_PAR:
            begin
               if (rx_mid)
               begin
                  rx_par_q <= uart_rx_in;
                  rx_st_q  <= `ST_STOP;
               end
            end
            `ST_STOP:
            begin
               if (rx_mid)
                  rx_st_q <= `ST_IDLE;
            end
            default:
               rx_st_q <= `ST_IDLE;
         endcase
         // first good indicator or delimiter byte fixes the protocol for the session
         if (good_byte && mode == `MODE_UNKNOWN)
         begin
            if (THREE_WIRE != 0 && rx_sh_q == `SLIP_DELIM)
               mode <= `MODE_THREE; // R4
            else if (rx_sh_q == `CMD_INDICATOR)
               mode <= `MODE_FOUR; // R4
         end
         if (good_byte && consumed)
            xoff_q <= (rx_sh_q == `XOFF_CHAR); // R10
         if (push)
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
         begin
            rx_data <= mem[rd_q];
            rd_q    <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
            rx_valid <= 1'b1;
         else if (rx_ready)
            rx_valid <= 1'b0;
         case ({push, pop})
            2'b10:   cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            2'b01:   cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            default: cnt_q <= cnt_q;
         endcase
      end
   end

   // ====================================================
   // receive throttle, sleep and software flow requests
   reg  asleep_q;
   reg  thr_prev_q;
   reg  above_q;
   reg  send_xoff_q;
   reg  send_xon_q;
   wire above;

   assign above = (cnt_q > THRESHOLD);

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_throttle_out <= 1'b0;
         asleep_q        <= 1'b0;
         thr_prev_q      <= 1'b0;
         above_q         <= 1'b0;
         wake_event      <= 1'b0;
      end
      else
      begin
         asleep_q   <= sleep_req && (mode != `MODE_THREE);
         thr_prev_q <= tx_throttle_in;
         above_q    <= above;
         // host lowers its throttle line to wake a sleeping device
         wake_event <= asleep_q && thr_prev_q && !tx_throttle_in; // R11
         if (mode == `MODE_THREE)
            rx_throttle_out <= 1'b0;
         else
            rx_throttle_out <= above || asleep_q; // R8 R11 R14
      end
   end

   // ====================================================
   // transmitter
   reg  [`ST_W-1:0]      tx_st_q;
   reg  [7:0]            tx_sh_q;
   reg  [`BIT_CNT_W-1:0] tx_cnt_q;
   reg                   tx_par_q;
   reg                   last_q;
   reg                   in_pkt_q;
   reg                   flow_q;
   wire                  blocked;
   wire                  take;
   wire                  flow_pend;
   wire                  tx_idle_now;

   // four-wire pauses on the line, three-wire on a received XOFF
   assign blocked     = (mode == `MODE_THREE) ? xoff_q : tx_throttle_in; // R7 R9 R10
   assign take        = tx_valid && tx_ready;
   assign flow_pend   = send_xoff_q || send_xon_q;
   assign tx_idle_now = (tx_st_q == `ST_IDLE) && !take;
   assign tx_restart  = (tx_st_q == `ST_WAIT) && (flow_q || !blocked);
   assign apply_rate  = pend_q && (tx_st_q == `ST_STOP) && tx_end && last_q && !flow_q;

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         tx_st_q       <= `ST_IDLE;
         tx_sh_q       <= 8'h00;
         tx_cnt_q      <= {`BIT_CNT_W{1'b0}};
         tx_par_q      <= 1'b0;
         last_q        <= 1'b0;
         in_pkt_q      <= 1'b0;
         flow_q        <= 1'b0;
         send_xoff_q   <= 1'b0;
         send_xon_q    <= 1'b0;
         uart_tx_out   <= 1'b1;
         tx_ready      <= 1'b0;
         err_underflow <= 1'b0;
         div_q         <= `DEFAULT_DIV; // R2
         pend_div_q    <= `DEFAULT_DIV;
         pend_q        <= 1'b0;
         rate_switched <= 1'b0;
      end
      else
      begin
         tx_ready      <= tx_idle_now && !flow_pend;
         err_underflow <= 1'b0;
         rate_switched <= apply_rate;
         // three-wire: ask the host to pause or resume on threshold edges
         // the acknowledge goes out at the old rate, switch after its stop bit
         if (apply_rate)
         begin
            div_q  <= pend_div_q; // R3
            pend_q <= 1'b0;
         end
         // a request landing in the switch cycle stays pending
         if (rate_req)
         begin
            pend_div_q <= clamp_div(rate_div_in);
            pend_q     <= 1'b1;
         end
         case (tx_st_q)
            `ST_IDLE:
            begin
               if (take)
               begin
                  tx_sh_q  <= tx_data; // R12
                  last_q   <= tx_last;
                  in_pkt_q <= !tx_last;
                  flow_q   <= 1'b0;
                  tx_st_q  <= `ST_WAIT;
               end
               else if (flow_pend)
               begin
                  tx_sh_q     <= send_xoff_q ? `XOFF_CHAR : `XON_CHAR;
                  send_xoff_q <= 1'b0;
                  send_xon_q  <= send_xoff_q ? send_xon_q : 1'b0;
                  flow_q      <= 1'b1;
                  tx_st_q     <= `ST_WAIT;
               end
            end
            `ST_WAIT:
            begin
               // a held data byte never starts while the far end throttles us, XON/XOFF start anyway
               if (tx_restart)
               begin
                  uart_tx_out <= 1'b0; // R9
                  tx_par_q    <= ^tx_sh_q ^ parity_odd;
                  tx_st_q     <= `ST_START;
               end
            end
            `ST_START:
            begin
               if (tx_end)
               begin
                  uart_tx_out <= tx_sh_q[0];
                  tx_sh_q     <= {1'b0, tx_sh_q[7:1]};
                  tx_cnt_q    <= {`BIT_CNT_W{1'b0}};
                  tx_st_q     <= `ST_DATA;
               end
            end
            `ST_DATA:
            begin
               if (tx_end)
               begin
                  tx_cnt_q <= tx_cnt_q + 3'h1;
                  if (tx_cnt_q == `DATA_BITS - 1)
                  begin
                     uart_tx_out <= parity_en ? tx_par_q : 1'b1; // R5
                     tx_st_q     <= parity_en ? `ST_PAR : `ST_STOP;
                  end
                  else
                  begin
                     uart_tx_out <= tx_sh_q[0];
                     tx_sh_q     <= {1'b0, tx_sh_q[7:1]};
                  end
               end
            end
            `ST_PAR:
            begin
               if (tx_end)
               begin
                  uart_tx_out <= 1'b1;
                  tx_st_q     <= `ST_STOP;
               end
            end
            `ST_STOP:
            begin
               // the byte in flight always completes, throttle or not
               if (tx_end)
               begin
                  tx_st_q       <= `ST_IDLE; // R9
                  err_underflow <= in_pkt_q && !flow_q && !tx_valid; // R6
               end
            end
            default:
               tx_st_q <= `ST_IDLE;
         endcase
         // set after the launch so a crossing in the launch cycle is kept
         if (mode == `MODE_THREE && above && !above_q)
            send_xoff_q <= 1'b1; // R10
         if (mode == `MODE_THREE && !above && above_q)
            send_xon_q <= 1'b1; // R10
      end
   end

endmodule

// ==== pkg/hci_uart_map.vh ====
// How it works
// R1 - bit rate up to 4 Mbps
// R2 - start at 115.2 kbps after reset
// R3 - send rate-change acknowledge, then switch rate
// R4 - pick wire protocol from first command
// R5 - default frame eight data, one stop, no parity
// R6 - flag break, idle, framing, overflow, parity, underflow
// R7 - four-wire: per-byte handshake lines each way
// R8 - assert receive throttle past fill threshold
// R9 - transmit throttle: finish byte, start none
// R10 - three-wire: XON/XOFF software flow control
// R11 - four-wire sleep handshake over throttle lines
// R12 - carry commands, events, ACL both ways
// R13 - three-wire sleep messages, CRC pass through
// R14 - host stops sending while receive throttle high
`ifndef HCI_UART_MAP_VH
`define HCI_UART_MAP_VH

// ====================================================
// clock and bit rates
`define CLK_HZ          250000000
`define DEFAULT_BAUD    115200
`define MAX_BAUD        4000000
// divisors sized to the divider: 2170 rounds down at the default rate,
// 63 rounds up at the fastest so the link never runs above 4 Mbps
`define DEFAULT_DIV     16'h087a
`define MIN_DIV         16'h003f
`define DIV_W           16

// ====================================================
// character format
`define DATA_BITS       8
`define BIT_CNT_W       3
`define IDLE_BITS       4'ha
`define IDLE_CNT_W      4

// ====================================================
// protocol detection and flow characters
`define CMD_INDICATOR   8'h01
`define SLIP_DELIM      8'hc0
`define XON_CHAR        8'h11
`define XOFF_CHAR       8'h13
`define MODE_W          2
`define MODE_UNKNOWN    2'h0
`define MODE_FOUR       2'h1
`define MODE_THREE      2'h2

// ====================================================
// receive and transmit states
`define ST_W            3
`define ST_IDLE         3'h0
`define ST_START        3'h1
`define ST_DATA         3'h2
`define ST_PAR          3'h3
`define ST_STOP         3'h4
`define ST_WAIT         3'h5

`endif

// ==== rtl/bit_timer.v ====
`timescale 1ns/100ps
`include "hci_uart_map.vh"

module bit_timer
#(
   parameter DW = `DIV_W
)
(
   // clock and reset
   input  wire          clk_sys,
   input  wire          rst,
   // control
   input  wire          restart,
   input  wire [DW-1:0] div,
   // ticks
   output reg           mid_tick,
   output reg           end_tick
);

   reg [DW-1:0] cnt_q;

   // ====================================================
   // bit period counter, realigned by restart
   always @(posedge clk_sys)
   begin
      if (rst || restart)
      begin
         cnt_q    <= {DW{1'b0}};
         mid_tick <= 1'b0;
         end_tick <= 1'b0;
      end
      else
      begin
         mid_tick <= (cnt_q == (div >> 1));
         end_tick <= (cnt_q == div - {{(DW-1){1'b0}}, 1'b1});
         if (cnt_q >= div - {{(DW-1){1'b0}}, 1'b1})
            cnt_q <= {DW{1'b0}};
         else
            cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
      end
   end

endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/100ps

// ==========
// host end of the serial link
module host_model
(
   // clock
   input  wire clk_sys,
   // serial lines
   input  wire line_in,
   input  wire throttle_in,
   output reg  line_out
);
   integer   div = 2170;
   integer   rx_cnt = 0;
   integer   rx_bad = 0;
   integer   j;
   reg [7:0] rx_byte = 8'h00;

   initial line_out = 1'b1;

   // the throttle is honoured per byte only, a byte once started runs out
   task send(input [7:0] b, input pe, input pv, input sv);
      integer i;
   begin
      i = 0;
      while (throttle_in === 1'b1 && i < 60000)
      begin
         @(posedge clk_sys);
         i = i + 1;
      end
      // a throttle that never drops is reported as a bad byte
      if (i >= 60000)
         rx_bad = rx_bad + 1;
      line_out <= 1'b0;
      repeat (div) @(posedge clk_sys);
      for (i = 0; i < 8 + pe; i = i + 1)
      begin
         line_out <= (i < 8) ? b[i] : pv;
         repeat (div) @(posedge clk_sys);
      end
      line_out <= sv;
      repeat (div) @(posedge clk_sys);
      line_out <= 1'b1;
      @(posedge clk_sys);
   end
   endtask

   // mid-bit sampling at the divisor in force, which the bench moves after the ack
   initial
   begin
      forever
      begin
         @(negedge line_in);
         repeat (div / 2) @(posedge clk_sys);
         for (j = 0; j < 8; j = j + 1)
         begin
            repeat (div) @(posedge clk_sys);
            rx_byte[j] = line_in;
         end
         repeat (div) @(posedge clk_sys);
         if (line_in !== 1'b1)
            rx_bad = rx_bad + 1;
         rx_cnt = rx_cnt + 1;
      end
   end
endmodule

// ==== verification/hci_uart_transport_assertions.sv ====
`timescale 1ns/100ps
`include "hci_uart_map.vh"

// ==========
// port checks of the serial transport
module hci_uart_transport_assertions
(
   // clock and reset
   input  wire               clk_sys,
   input  wire               rst,
   // serial link
   input  wire               uart_tx_out,
   input  wire               rx_throttle_out,
   input  wire               tx_throttle_in,
   // byte streams
   input  wire [7:0]         rx_data,
   input  wire               rx_valid,
   input  wire               rx_ready,
   input  wire               tx_valid,
   input  wire               tx_ready,
   // control and status
   input  wire               sleep_req,
   input  wire [`MODE_W-1:0] mode,
   input  wire               rate_switched,
   input  wire               err_break,
   input  wire               err_framing
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_RESET_STATE: assert property (
      $fell(rst) |-> uart_tx_out && !rx_throttle_out && !rx_valid && !tx_ready
         && mode == `MODE_UNKNOWN) else $error("outputs not at rest after reset");
   AST_RX_HOLD: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("receive byte not held");
   AST_TX_TAKE: assert property (
      tx_valid && tx_ready |=> !tx_ready) else $error("ready stayed after take");
   AST_TX_IDLE: assert property (
      tx_ready |-> uart_tx_out) else $error("line low while idle");
   // a two-stage look at the throttle covers a synchronised input
   AST_THROTTLE_HOLD: assert property (
      tx_ready && tx_throttle_in && $past(tx_throttle_in) && $past(tx_throttle_in, 2)
         && mode != `MODE_THREE ##1 tx_throttle_in [*4] |-> uart_tx_out)
      else $error("start bit while throttled");
   AST_THREE_QUIET: assert property (
      mode == `MODE_THREE && $past(mode) == `MODE_THREE |-> !rx_throttle_out)
      else $error("throttle pin used in three-wire mode");
   AST_SLEEP_THROTTLE: assert property (
      $rose(sleep_req) && mode == `MODE_FOUR |-> ##[1:4] rx_throttle_out)
      else $error("sleep did not raise throttle");
   AST_RATE_IDLE: assert property (
      rate_switched |-> uart_tx_out ##1 !rate_switched)
      else $error("rate switched mid-character");
   AST_BREAK_FRAMING: assert property (
      err_break |-> err_framing ##1 !err_break) else $error("break without framing");
   AST_MODE_KEEP: assert property (
      mode != `MODE_UNKNOWN |=> $stable(mode)) else $error("mode changed");
endmodule

bind hci_uart_transport hci_uart_transport_assertions u_hci_uart_transport_assertions
(
   .clk_sys, .rst, .uart_tx_out, .rx_throttle_out, .tx_throttle_in, .rx_data,
   .rx_valid, .rx_ready, .tx_valid, .tx_ready, .sleep_req, .mode, .rate_switched,
   .err_break, .err_framing
);

// ==== verification/hci_uart_transport_tb.sv ====
`timescale 1ns/100ps
`include "hci_uart_map.vh"

module hci_uart_transport_tb;
   // ==========
   // design signals
   reg                clk_sys = 1'b0;
   reg                rst = 1'b1;
   reg                rx_ready = 1'b0;
   reg  [7:0]         tx_data = 8'h00;
   reg                tx_last = 1'b0;
   reg                tx_valid = 1'b0;
   reg                tx_throttle_in = 1'b0;
   reg                parity_en = 1'b0;
   reg                parity_odd = 1'b0;
   reg                rate_req = 1'b0;
   reg  [`DIV_W-1:0]  rate_div_in = 16'h0000;
   reg                sleep_req = 1'b0;
   wire [7:0]         rx_data;
   wire [`MODE_W-1:0] mode;
   wire               uart_rx_in, uart_tx_out, rx_throttle_out, rx_valid, tx_ready;
   wire               rate_switched, wake_event, err_break, err_idle, err_framing;
   wire               err_overflow, err_parity, err_underflow;
   // pulses counted so scenarios can wait on them
   wire [8:0]         ev = {wake_event, rx_throttle_out, rate_switched, err_underflow,
                            err_parity, err_overflow, err_framing, err_idle, err_break};
   integer            ec [0:8];
   integer            bad_count = 0;
   integer            compares = 0;
   integer            i, n, m, e;

   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
      for (e = 0; e < 9; e = e + 1)
         if (ev[e] === 1'b1)
            ec[e] <= ec[e] + 1;

   hci_uart_transport u_hci_uart_transport
   (
      .clk_sys, .rst, .uart_rx_in, .uart_tx_out, .rx_throttle_out, .tx_throttle_in,
      .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_last, .tx_valid, .tx_ready,
      .parity_en, .parity_odd, .rate_req, .rate_div_in, .sleep_req, .mode,
      .rate_switched, .wake_event, .err_break, .err_idle, .err_framing,
      .err_overflow, .err_parity, .err_underflow
   );

   host_model u_host_model
   (
      .clk_sys, .line_in(uart_tx_out), .throttle_in(rx_throttle_out), .line_out(uart_rx_in)
   );

   // ==========
   // shared tasks
   task chk(input [15:0] got, input [15:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task wrap_up;
   begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   task tick(input integer c);
      repeat (c) @(posedge clk_sys);
   endtask

   task clr;
      for (i = 0; i < 9; i = i + 1)
         ec[i] = 0;
   endtask

   task lim(input integer k);
   begin
      chk(k < 60000, 1'b1);
      if (k >= 60000)
         wrap_up;
   end
   endtask

   // index 9 waits on bytes seen by the host
   task wait_ev(input integer x, input integer c);
      integer k;
   begin
      k = 0;
      while ((x == 9 ? u_host_model.rx_cnt : ec[x]) < c && k < 60000)
      begin
         @(posedge clk_sys);
         k = k + 1;
      end
      lim(k);
   end
   endtask

   task put(input [7:0] b, input l);
      integer k;
   begin
      tx_data <= b;
      tx_last <= l;
      tx_valid <= 1'b1;
      k = 0;
      @(posedge clk_sys);
      while (tx_ready !== 1'b1 && k < 60000)
      begin
         @(posedge clk_sys);
         k = k + 1;
      end
      lim(k);
      tx_valid <= 1'b0;
      @(posedge clk_sys);
   end
   endtask

   task pop(input [7:0] x);
      integer k;
   begin
      rx_ready <= 1'b1;
      k = 0;
      @(posedge clk_sys);
      while (rx_valid !== 1'b1 && k < 60000)
      begin
         @(posedge clk_sys);
         k = k + 1;
      end
      lim(k);
      chk(rx_data, x);
      rx_ready <= 1'b0;
      @(posedge clk_sys);
   end
   endtask

   task do_reset;
   begin
      rst <= 1'b1;
      tick(10);
      rst <= 1'b0;
   end
   endtask

   // ==========
   // scenarios
   task t_boot(input [7:0] ind, input [7:0] ack, input [1:0] md, input [15:0] rq,
               input integer hd);
   begin
      clr;
      n = u_host_model.rx_cnt;
      rate_div_in <= rq;
      rate_req <= 1'b1;
      tick(1);
      rate_req <= 1'b0;
      fork
         u_host_model.send(ind, 1'b0, 1'b0, 1'b1);
         put(ack, 1'b1);
      join
      wait_ev(9, n + 1);
      chk(u_host_model.rx_byte, ack);
      chk(u_host_model.rx_bad, 0);
      pop(ind);
      chk(mode, md);
      wait_ev(6, 1);
      u_host_model.div = hd;
      put(8'h3a, 1'b1);
      wait_ev(9, n + 2);
      chk(u_host_model.rx_byte, 8'h3a);
      $display("boot done");
   end
   endtask

   task t_flow;
   begin
      clr;
      fork
         for (m = 0; m < 16; m = m + 1)
            u_host_model.send(8'h20 + m[7:0], 1'b0, 1'b0, 1'b1);
      join_none
      wait_ev(7, 1);
      for (i = 0; i < 16; i = i + 1)
         pop(8'h20 + i[7:0]);
      tick(4);
      chk(rx_throttle_out, 0);
      chk(ec[3], 0);
      $display("flow done");
   end
   endtask

   task t_hold;
   begin
      clr;
      n = u_host_model.rx_cnt;
      put(8'h3c, 1'b0);
      tick(200);
      tx_throttle_in <= 1'b1;
      wait_ev(9, n + 1);
      chk(u_host_model.rx_byte, 8'h3c);
      wait_ev(5, 1);
      put(8'ha5, 1'b1);
      tick(700);
      chk(u_host_model.rx_cnt, n + 1);
      tx_throttle_in <= 1'b0;
      wait_ev(9, n + 2);
      chk(u_host_model.rx_byte, 8'ha5);
      $display("hold done");
   end
   endtask

   task t_err;
   begin
      clr;
      u_host_model.send(8'h55, 1'b0, 1'b0, 1'b0);
      wait_ev(2, 1);
      u_host_model.send(8'h00, 1'b0, 1'b0, 1'b0);
      wait_ev(0, 1);
      parity_en <= 1'b1;
      u_host_model.send(8'h07, 1'b1, 1'b0, 1'b1);
      wait_ev(4, 1);
      u_host_model.send(8'h07, 1'b1, 1'b1, 1'b1);
      pop(8'h07);
      parity_odd <= 1'b1;
      u_host_model.send(8'h07, 1'b1, 1'b0, 1'b1);
      pop(8'h07);
      parity_en <= 1'b0;
      parity_odd <= 1'b0;
      wait_ev(1, 1);
      sleep_req <= 1'b1;
      tick(6);
      chk(rx_throttle_out, 1);
      tx_throttle_in <= 1'b1;
      tick(4);
      tx_throttle_in <= 1'b0;
      wait_ev(8, 1);
      sleep_req <= 1'b0;
      $display("error and sleep done");
   end
   endtask

   task t_three;
   begin
      clr;
      n = u_host_model.rx_cnt;
      u_host_model.send(8'h13, 1'b0, 1'b0, 1'b1);
      put(8'h77, 1'b1);
      tick(800);
      chk(u_host_model.rx_cnt, n);
      u_host_model.send(8'h11, 1'b0, 1'b0, 1'b1);
      wait_ev(9, n + 1);
      chk(u_host_model.rx_byte, 8'h77);
      chk(rx_valid, 0);
      fork
         for (m = 0; m < 18; m = m + 1)
            u_host_model.send(8'h40 + m[7:0], 1'b0, 1'b0, 1'b1);
      join_none
      wait_ev(3, 1);
      chk(u_host_model.rx_byte, 8'h13);
      for (i = 0; i < 17; i = i + 1)
         pop(8'h40 + i[7:0]);
      wait_ev(9, n + 3);
      chk(u_host_model.rx_byte, 8'h11);
      $display("three-wire done");
   end
   endtask

   initial
   begin
      clr;
      do_reset;
      t_boot(8'h01, 8'h5a, `MODE_FOUR, 16'h0040, 64);
      t_flow;
      t_hold;
      t_err;
      do_reset;
      u_host_model.div = 2170;
      t_boot(8'hc0, 8'h66, `MODE_THREE, 16'h0010, 63);
      t_three;
      wrap_up;
   end
endmodule
